// >>> core/bc_support_regs.sv
// Controller list pointer, frame and message timers, condition code register
`timescale 1ns/1ns

// Function
// - Host base address register, cleared on reset
// - Pointer read-only; jumps only by jump op
// - Start copies base into pointer, begins running
// - Pointer steps over op/parameter word pairs
// - Pointer advances after op and its outcome
// - Load frame timer op writes frame time
// - Frame timer decrements only after start op
// - Frame timer counts 100 us per step
// - Message timer loaded from message word 4
// - Message timer spans mid-sync to mid-sync
// - Message timer counts 1 us per step
// - Read gives condition code, write gives flags
// - Low eight flags from host or flag op
// - Compare ops set or clear bits 1-0
// - Bits 14-8 report last message outcome
// - Running set on start with both enables
// - Running cleared by enable drop, halt, illegal
// - Illegal op raises trap when enabled
// - Bits 14:13 report retry count
// - Bit 12 flags a failed last message
module bc_support_regs
    import bc_regs_pkg::*;
(
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           srst,
    // Host register port
    input  wire logic [15:0]    host_addr,
    input  wire logic           host_wr,
    input  wire logic           host_rd,
    input  wire logic [15:0]    host_wdata,
    output logic      [15:0]    host_rdata_ff,
    // Master configuration and pins
    input  wire logic           controller_enable_pin,
    input  wire logic           controller_enable,
    input  wire logic           controller_start_request,
    input  wire logic           trap_int_enable,
    // List sequencer
    input  wire op_exec_type    op_exec,
    input  wire logic           op_done,
    input  wire logic           msg_mid_sync,
    input  wire logic [15:0]    msg_word4,
    input  wire msg_result_type msg_result,
    // Status outputs
    output logic [15:0]         list_pointer_ff,
    output logic                controller_running_status_ff,
    output logic                illegal_op_trap_interrupt_ff,
    output logic                frame_timer_zero_ff,
    output logic                message_timer_zero_ff
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [15:0] base_addr_ff;
    logic [15:0] frame_time_ff;
    logic        frame_run_ff;
    logic [15:0] next_msg_ff;
    logic [15:0] cond_code_ff;
    logic        ena_pin_meta_ff;
    logic        ena_pin_sync_ff;
    logic [7:0]  us_div_ff;
    logic        us_tick_ff;
    logic [7:0]  frame_div_ff;
    logic [7:0]  msg_div_ff;
    logic        msg_tick;
    logic        running;
    logic        enabled;
    logic        op_go;
    logic        frame_tick;
    logic [7:0]  nxt_flags;

    if (CYC_PER_US < 2 || CYC_PER_US > 255 || FRAME_LSB_US > 255) begin : g_timing_check
        $error("Timing constants do not fit the tick dividers");
    end

    function automatic logic [7:0] flag_apply(input logic [7:0] cur,
                                              input logic [15:0] cmd);
        // High byte clears, low byte sets, both toggle
        flag_apply = (cur & ~cmd[15:8] & ~cmd[7:0])
                   | (~cur & cmd[15:8] & cmd[7:0])
                   | (cmd[7:0] & ~cmd[15:8]);
    endfunction : flag_apply

    assign running    = controller_running_status_ff;
    assign enabled    = ena_pin_sync_ff & controller_enable;
    assign op_go      = op_exec.valid & running;
    assign frame_tick = us_tick_ff & (frame_div_ff == 8'(FRAME_LSB_US - 1));
    assign msg_tick   = (msg_div_ff == 8'(CYC_PER_US - 1));

    // ****************************************
    // Enable pin synchroniser
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ena_pin_meta_ff <= 1'b0;
            ena_pin_sync_ff <= 1'b0;
        end else begin
            ena_pin_meta_ff <= controller_enable_pin;
            ena_pin_sync_ff <= ena_pin_meta_ff;
        end
    end

    // ****************************************
    // Microsecond and frame step dividers
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            us_div_ff  <= 8'h00;
            us_tick_ff <= 1'b0;
        end else begin
            us_tick_ff <= (us_div_ff == 8'(CYC_PER_US - 1));
            if (us_div_ff == 8'(CYC_PER_US - 1)) begin
                us_div_ff <= 8'h00;
            end else begin
                us_div_ff <= us_div_ff + 8'h01;
            end
        end
    end

    // Restarted by the start op; the shared us divider runs on, so the first step is 99 to 100 us
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_div_ff <= 8'h00;
        end else if (op_go && op_exec.code == START_FRAME_TIMER_OP) begin
            frame_div_ff <= 8'h00;
        end else if (frame_tick) begin
            frame_div_ff <= 8'h00;
        end else if (us_tick_ff) begin
            frame_div_ff <= frame_div_ff + 8'h01;
        end
    end

    // ****************************************
    // Base address register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            base_addr_ff <= BASE_ADDR_RST;
        end else if (host_wr && host_addr == BASE_ADDR_OFS) begin
            base_addr_ff <= host_wdata;
        end
    end

    // ****************************************
    // Run / stop status
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            controller_running_status_ff <= 1'b0;
        end else if (!enabled) begin
            controller_running_status_ff <= 1'b0;
        end else if (op_go && (op_exec.code == HALT_OP || op_exec.code == ILLEGAL_OP)) begin
            controller_running_status_ff <= 1'b0;
        end else if (controller_start_request) begin
            controller_running_status_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            illegal_op_trap_interrupt_ff <= 1'b0;
        end else begin
            illegal_op_trap_interrupt_ff <= op_go && op_exec.code == ILLEGAL_OP
                                            && trap_int_enable;
        end
    end

    // ****************************************
    // Instruction list pointer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            list_pointer_ff <= POINTER_RST;
        end else if (!running && enabled && controller_start_request) begin
            list_pointer_ff <= base_addr_ff;
        end else if (op_go && op_exec.code == JUMP_OP) begin
            list_pointer_ff <= op_exec.param;
        end else if (running && op_done) begin
            list_pointer_ff <= list_pointer_ff + LIST_ENTRY_WORDS;
        end
    end

    // ****************************************
    // Frame timer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_time_ff <= FRAME_TIME_RST;
            frame_run_ff  <= 1'b0;
        end else if (host_wr && host_addr == FRAME_TIME_OFS) begin
            frame_time_ff <= host_wdata;
            frame_run_ff  <= 1'b0;
        end else if (op_go && op_exec.code == LOAD_FRAME_TIMER_OP) begin
            frame_time_ff <= op_exec.param;
            frame_run_ff  <= 1'b0;
        end else if (op_go && op_exec.code == START_FRAME_TIMER_OP) begin
            frame_run_ff <= 1'b1;
        end else if (frame_run_ff && frame_tick) begin
            if (frame_time_ff == 16'h0000) begin
                frame_run_ff <= 1'b0;
            end else begin
                frame_time_ff <= frame_time_ff - 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_timer_zero_ff <= 1'b0;
        end else begin
            frame_timer_zero_ff <= (frame_time_ff == 16'h0000);
        end
    end

    // ****************************************
    // Time to next message
    // ****************************************
    // Own divider, restarted at mid-sync so the first step is a full microsecond
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            msg_div_ff <= 8'h00;
        end else if (msg_mid_sync || msg_tick) begin
            msg_div_ff <= 8'h00;
        end else begin
            msg_div_ff <= msg_div_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            next_msg_ff <= NEXT_MSG_RST;
        end else if (msg_mid_sync) begin
            next_msg_ff <= msg_word4;
        end else if (msg_tick && next_msg_ff != 16'h0000) begin
            next_msg_ff <= next_msg_ff - 16'(MSG_LSB_US);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            message_timer_zero_ff <= 1'b0;
        end else begin
            message_timer_zero_ff <= (next_msg_ff == 16'h0000);
        end
    end

    // ****************************************
    // Condition code register
    // ****************************************
    always_comb begin
        nxt_flags = cond_code_ff[CC_FLAG_W-1:0];
        if (host_wr && host_addr == COND_CODE_OFS) begin
            nxt_flags = flag_apply(nxt_flags, host_wdata);
        end
        if (op_go && op_exec.code == FLAG_UPDATE_OP) begin
            nxt_flags = flag_apply(nxt_flags, op_exec.param);
        end
        if (op_go && op_exec.code == COMPARE_FRAME_TIMER_OP) begin
            nxt_flags[CC_LESS_BIT]  = frame_time_ff < op_exec.param;
            nxt_flags[CC_EQUAL_BIT] = frame_time_ff == op_exec.param;
        end
        if (op_go && op_exec.code == COMPARE_MESSAGE_TIMER_OP) begin
            nxt_flags[CC_LESS_BIT]  = next_msg_ff < op_exec.param;
            nxt_flags[CC_EQUAL_BIT] = next_msg_ff == op_exec.param;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cond_code_ff <= COND_CODE_RST;
        end else begin
            cond_code_ff[CC_FLAG_W-1:0] <= nxt_flags;
            cond_code_ff[CC_RUN_BIT]    <= controller_running_status_ff;
            if (msg_result.valid) begin
                cond_code_ff[CC_RETRY_MSB:CC_RETRY_LSB]  <= msg_result.retries;
                cond_code_ff[CC_FAIL_BIT]                <= msg_result.failed;
                cond_code_ff[CC_RESULT_MSB:CC_RESULT_LSB] <= msg_result.results;
            end
        end
    end

    // ****************************************
    // Host read port
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            host_rdata_ff <= 16'h0000;
        end else if (host_rd) begin
            case (host_addr)
                BASE_ADDR_OFS:  host_rdata_ff <= base_addr_ff;
                POINTER_OFS:    host_rdata_ff <= list_pointer_ff;
                FRAME_TIME_OFS: host_rdata_ff <= frame_time_ff;
                NEXT_MSG_OFS:   host_rdata_ff <= next_msg_ff;
                COND_CODE_OFS:  host_rdata_ff <= cond_code_ff;
                default:        host_rdata_ff <= 16'h0000;
            endcase
        end
    end

endmodule : bc_support_regs

// >>> pkg/bc_regs_pkg.sv
// Shared constants and carrier types for the controller support registers
package bc_regs_pkg;

    // ****************************************
    // Register offsets (word addresses)
    // ****************************************
    localparam logic [15:0] BASE_ADDR_OFS  = 16'h0033;
    localparam logic [15:0] POINTER_OFS    = 16'h0034;
    localparam logic [15:0] FRAME_TIME_OFS = 16'h0035;
    localparam logic [15:0] NEXT_MSG_OFS   = 16'h0036;
    localparam logic [15:0] COND_CODE_OFS  = 16'h0037;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] BASE_ADDR_RST  = 16'h0000;
    localparam logic [15:0] POINTER_RST    = 16'h0000;
    localparam logic [15:0] FRAME_TIME_RST = 16'h0000;
    localparam logic [15:0] NEXT_MSG_RST   = 16'h0000;
    localparam logic [15:0] COND_CODE_RST  = 16'h0000;

    // ****************************************
    // Condition code fields
    // ****************************************
    localparam int CC_RUN_BIT    = 15;
    localparam int CC_RETRY_MSB  = 14;
    localparam int CC_RETRY_LSB  = 13;
    localparam int CC_FAIL_BIT   = 12;
    localparam int CC_RESULT_MSB = 11;
    localparam int CC_RESULT_LSB = 8;
    localparam int CC_FLAG_W     = 8;
    localparam int CC_LESS_BIT   = 0;
    localparam int CC_EQUAL_BIT  = 1;

    // Words per list entry: op code word then parameter word
    localparam logic [15:0] LIST_ENTRY_WORDS = 16'h0002;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int US_NS         = 1000;
    localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRAME_LSB_US  = 100;
    localparam int MSG_LSB_US    = 1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        JUMP_OP                  = 4'b0001,
        LOAD_FRAME_TIMER_OP      = 4'b0010,
        START_FRAME_TIMER_OP     = 4'b0011,
        FLAG_UPDATE_OP           = 4'b0100,
        COMPARE_FRAME_TIMER_OP   = 4'b0101,
        COMPARE_MESSAGE_TIMER_OP = 4'b0110,
        HALT_OP                  = 4'b0111,
        ILLEGAL_OP               = 4'b1111,
        OTHER_OP                 = 4'b0000
    } op_code_type;

    typedef struct packed {
        logic        valid;
        op_code_type code;
        logic [15:0] param;
    } op_exec_type;

    typedef struct packed {
        logic       valid;
        logic [1:0] retries;
        logic       failed;
        logic [3:0] results;
    } msg_result_type;

endpackage : bc_regs_pkg

// >>> sim/bc_support_regs_asserts.sv
// Checker for the controller support registers
`timescale 1ns/1ns
module bc_support_regs_asserts
    import bc_regs_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // Host port
    input wire logic [15:0] host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata_ff,
    // Control and sequencer
    input wire logic        controller_enable,
    input wire logic        controller_start_request,
    input wire logic        trap_int_enable,
    input wire op_exec_type op_exec,
    input wire logic        op_done,
    // Status
    input wire logic [15:0] list_pointer_ff,
    input wire logic        controller_running_status_ff,
    input wire logic        illegal_op_trap_interrupt_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ****
    // Helpers
    // ****
    // Mirror of the base register, so the start copy can be judged
    logic [15:0] base_ff;
    wire run = controller_running_status_ff;
    wire go = controller_start_request;
    wire ex = op_exec.valid && run;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            base_ff <= BASE_ADDR_RST;
        end else if (host_wr && host_addr == BASE_ADDR_OFS) begin
            base_ff <= host_wdata;
        end
    end
    sequence trap_s;
        ex && op_exec.code == ILLEGAL_OP && trap_int_enable;
    endsequence
    sequence pulse_s;
        illegal_op_trap_interrupt_ff ##1 !illegal_op_trap_interrupt_ff;
    endsequence
    // ****
    // Properties
    // ****
    base_read_a: assert property (
        host_rd && !host_wr && host_addr == BASE_ADDR_OFS |=> host_rdata_ff == base_ff)
        else $error("base readback wrong");
    start_copy_a: assert property ($rose(run) |-> list_pointer_ff == base_ff)
        else $error("pointer not copied");
    pair_step_a: assert property (
        run && op_done && !op_exec.valid && !go
        |=> list_pointer_ff == $past(list_pointer_ff) + LIST_ENTRY_WORDS)
        else $error("pointer step wrong");
    jump_load_a: assert property (
        ex && op_done && op_exec.code == JUMP_OP |=> list_pointer_ff == $past(op_exec.param))
        else $error("jump target wrong");
    pointer_hold_a: assert property (
        !op_done && !op_exec.valid && !go |=> $stable(list_pointer_ff))
        else $error("pointer moved");
    op_stop_a: assert property (ex && op_exec.code inside {HALT_OP, ILLEGAL_OP} |=> !run)
        else $error("still running after stop op");
    trap_pulse_a: assert property (trap_s |=> pulse_s)
        else $error("trap pulse wrong");
    bit_drop_a: assert property (!controller_enable |=> !run)
        else $error("running without enable");
endmodule : bc_support_regs_asserts

bind bc_support_regs bc_support_regs_asserts chk (.*);

// >>> sim/bc_host_model.sv
// Host processor model for the register port
`timescale 1ns/1ns
module bc_host_model (
    // Clock and read data
    input wire logic [15:0] host_rdata_ff,
    input wire logic        ref_clk,
    // Strobes and bus
    output logic [15:0]     host_addr,
    output logic            host_wr,
    output logic            host_rd,
    output logic [15:0]     host_wdata
);
    initial begin
        host_addr = 16'h0000;
        host_wdata = 16'h0000;
        host_wr = 1'b0;
        host_rd = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge ref_clk);
        host_wr = 1'b0;
        // Released bus shows the inverse, never stale data
        host_addr = ~a;
        host_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge ref_clk);
        host_rd = 1'b0;
        host_addr = ~a;
        d = host_rdata_ff;
    endtask : rd
endmodule : bc_host_model

// >>> sim/bc_support_regs_tb.sv
// Self-checking bench for the controller support registers
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module bc_support_regs_tb
    import bc_regs_pkg::*;
;
    logic           ref_clk = 1'b0;
    logic           srst = 1'b1;
    logic [15:0]    host_addr, host_wdata, host_rdata_ff, list_pointer_ff, msg_word4, rd_val;
    logic           host_wr, host_rd, op_done = 1'b0, msg_mid_sync = 1'b0;
    logic           controller_enable_pin = 1'b1, controller_enable = 1'b1;
    logic           controller_start_request = 1'b0, trap_int_enable = 1'b1;
    logic           controller_running_status_ff, illegal_op_trap_interrupt_ff;
    logic           frame_timer_zero_ff, message_timer_zero_ff;
    op_exec_type    op_exec = '0;
    msg_result_type msg_result = '0;
    int             fails = 0;
    int             n_compared = 0;
    always #4 ref_clk = ~ref_clk;
    bc_support_regs dut (.*);
    bc_host_model host (.*);
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic op(input op_code_type c, input logic [15:0] p, input logic same);
        @(negedge ref_clk);
        op_exec = '{1'b1, c, p};
        op_done = same;
        @(negedge ref_clk);
        op_exec = '0;
        op_done = !same;
        @(negedge ref_clk);
        op_done = 1'b0;
    endtask : op
    task automatic start_bc();
        @(negedge ref_clk);
        controller_start_request = 1'b1;
        @(negedge ref_clk);
        controller_start_request = 1'b0;
        `CHK(controller_running_status_ff, 1'b1)
    endtask : start_bc
    task automatic bad(input logic exp);
        @(negedge ref_clk);
        op_exec = '{1'b1, ILLEGAL_OP, 16'h0000};
        @(negedge ref_clk);
        op_exec = '0;
        `CHK(illegal_op_trap_interrupt_ff, exp)
        @(negedge ref_clk);
        `CHK(illegal_op_trap_interrupt_ff, 1'b0)
        `CHK(controller_running_status_ff, 1'b0)
    endtask : bad
    task automatic sync(input logic [15:0] w);
        @(negedge ref_clk);
        msg_word4 = w;
        msg_mid_sync = 1'b1;
        @(negedge ref_clk);
        msg_mid_sync = 1'b0;
        msg_word4 = ~w;
        host.rd(NEXT_MSG_OFS, rd_val);
        `CHK(rd_val, w)
    endtask : sync
    task automatic t_regs();
        host.wr(POINTER_OFS, 16'hBEEF);
        host.wr(NEXT_MSG_OFS, 16'hBEEF);
        for (int i = 0; i < 6; i++) begin
            host.rd(BASE_ADDR_OFS + 16'(i), rd_val);
            `CHK(rd_val, 16'h0000)
        end
        $display("t_regs done");
    endtask : t_regs
    task automatic t_list();
        host.wr(BASE_ADDR_OFS, 16'h1234);
        host.rd(BASE_ADDR_OFS, rd_val);
        `CHK(rd_val, 16'h1234)
        start_bc();
        `CHK(list_pointer_ff, 16'h1234)
        op(OTHER_OP, 16'h0000, 1'b0);
        `CHK(list_pointer_ff, 16'h1236)
        op(JUMP_OP, 16'h0100, 1'b1);
        host.rd(POINTER_OFS, rd_val);
        `CHK(rd_val, 16'h0100)
        $display("t_list done");
    endtask : t_list
    task automatic t_flags();
        op(LOAD_FRAME_TIMER_OP, 16'h0005, 1'b0);
        host.rd(FRAME_TIME_OFS, rd_val);
        `CHK(rd_val, 16'h0005)
        host.wr(COND_CODE_OFS, 16'h0003);
        op(FLAG_UPDATE_OP, 16'h0081, 1'b0);
        host.wr(COND_CODE_OFS, 16'h0101);
        host.rd(COND_CODE_OFS, rd_val);
        `CHK(rd_val[7:0], 8'h82)
        `CHK(rd_val[15], 1'b1)
        op(COMPARE_FRAME_TIMER_OP, 16'h0006, 1'b0);
        host.rd(COND_CODE_OFS, rd_val);
        `CHK(rd_val[7:0], 8'h81)
        op(COMPARE_MESSAGE_TIMER_OP, 16'h0000, 1'b0);
        host.rd(COND_CODE_OFS, rd_val);
        `CHK(rd_val[7:0], 8'h82)
        $display("t_flags done");
    endtask : t_flags
    task automatic t_msg();
        sync(16'h0003);
        repeat (236) @(negedge ref_clk);
        `CHK(message_timer_zero_ff, 1'b0)
        repeat (150) @(negedge ref_clk);
        `CHK(message_timer_zero_ff, 1'b1)
        sync(16'h0005);
        @(negedge ref_clk);
        msg_result = '{1'b1, 2'b10, 1'b1, 4'hA};
        @(negedge ref_clk);
        msg_result = '0;
        host.rd(COND_CODE_OFS, rd_val);
        `CHK(rd_val[14:13], 2'b10)
        `CHK(rd_val[12], 1'b1)
        `CHK(rd_val[11:8], 4'hA)
        $display("t_msg done");
    endtask : t_msg
    task automatic t_stop();
        op(HALT_OP, 16'h0000, 1'b0);
        `CHK(controller_running_status_ff, 1'b0)
        rd_val = list_pointer_ff;
        op(OTHER_OP, 16'h0000, 1'b0);
        `CHK(list_pointer_ff, rd_val)
        start_bc();
        bad(1'b1);
        start_bc();
        controller_enable = 1'b0;
        @(negedge ref_clk);
        `CHK(controller_running_status_ff, 1'b0)
        controller_enable = 1'b1;
        start_bc();
        controller_enable_pin = 1'b0;
        repeat (4) @(negedge ref_clk);
        `CHK(controller_running_status_ff, 1'b0)
        controller_enable_pin = 1'b1;
        trap_int_enable = 1'b0;
        repeat (3) @(negedge ref_clk);
        start_bc();
        bad(1'b0);
        trap_int_enable = 1'b1;
        $display("t_stop done");
    endtask : t_stop
    task automatic t_frame();
        start_bc();
        op(LOAD_FRAME_TIMER_OP, 16'h0002, 1'b0);
        repeat (300) @(negedge ref_clk);
        host.rd(FRAME_TIME_OFS, rd_val);
        `CHK(rd_val, 16'h0002)
        op(START_FRAME_TIMER_OP, 16'h0000, 1'b0);
        repeat (12000) @(negedge ref_clk);
        `CHK(frame_timer_zero_ff, 1'b0)
        repeat (13500) @(negedge ref_clk);
        host.rd(FRAME_TIME_OFS, rd_val);
        `CHK(rd_val, 16'h0000)
        repeat (12600) @(negedge ref_clk);
        `CHK(frame_timer_zero_ff, 1'b1)
        $display("t_frame done");
    endtask : t_frame
    initial begin
        msg_word4 = 16'h0000;
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        t_regs();
        t_list();
        t_flags();
        t_msg();
        t_stop();
        t_frame();
        results();
    end
    // Tests need about 39000 cycles
    initial begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        results();
    end
endmodule : bc_support_regs_tb
